// >>> shared/tfex_defines.svh
`ifndef TFEX_DEFINES_SVH
`define TFEX_DEFINES_SVH

// Register byte offsets
`define TFEX_OFF_PSW 12'h000
`define TFEX_OFF_STATUS 12'h004
`define TFEX_OFF_VERSION 12'h008
`define TFEX_OFF_TRCCNT 12'h00C

// Status word fields
`define TFEX_PSW_TCH 15
`define TFEX_PSW_TCL 14
`define TFEX_PSW_SUP 13
`define TFEX_PSW_RST 16'h2700
`define TFEX_VERSION_RST 8'h01

// Trace modes (high bit, low bit)
`define TFEX_TM_NONE 2'h0
`define TFEX_TM_FLOW 2'h1
`define TFEX_TM_ALL 2'h2

// Vectors
`define TFEX_VEC_TRACE 8'h09
`define TFEX_VEC_FORMAT 8'h0E

// Frame formats
`define TFEX_FMT_LONG_BUS 4'hB
`define TFEX_FMT_VALID_MASK 16'h0E07

// Descriptor fields that a proper call or return must carry
`define TFEX_MOD_OPT_OK 3'h0
`define TFEX_MOD_TYPE_OK 2'h0

`endif

// >>> shared/tfex_pkg.sv
package tfex_pkg;
  typedef enum logic [1:0] {
    ST_RUN,
    ST_FORCED,
    ST_TRACE,
    ST_INT
  } tfex_state_t;
endpackage

// >>> src/tfex_unit.sv
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "tfex_defines.svh"
// Overview of operation
// - Trace decision uses trace bits latched when the instruction starts.
// - Both trace bits zero means no tracing at all.
// - Mode 01 traces branches, jumps, traps, returns and coproc flow ops.
// - Mode 01 never traces sequential instructions.
// - Mode 01 also traces instructions that may modify the status word.
// - Breakpoint is a flow change only if its replacement changes flow.
// - Mode 10 traces every executed instruction.
// - Suspended instruction keeps its trace until it resumes and completes.
// - Pending interrupt waits until trace processing has finished.
// - A forced exception is processed before the trace exception.
// - Illegal or unimplemented instructions are never traced.
// - Trace runs after the instruction ends, before the next one starts.
// - Trace entry copies status word, sets supervisor, clears trace bits.
// - Trace uses vector 9, stacking offset, status copy, next pc.
// - Stop under all-tracing loads status word, traces, never stops.
// - Return checks format; long bus frame also checks version at SP+54.
// - Module call and return check option, type and memory-manager veto.
// - Coproc restore hands format word over; coprocessor flags errors.
// - Format error stacks short frame, vector 14, pc of detecting instr.
module tfex_unit #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instrStart,
  input wire logic instrDone,
  input wire logic instrSuspend,
  input wire logic instrIllegal,
  input wire logic instrFlowChange,
  input wire logic instrSrWrite,
  input wire logic instrIsBkpt,
  input wire logic bkptReplaceFlow,
  input wire logic instrIsStop,
  input wire logic forcedExc,
  input wire logic excDone,
  input wire logic intPending,
  input wire logic [31:0] curPc,
  input wire logic [31:0] nextPc,
  input wire logic srLoad,
  input wire logic [15:0] srLoadData,
  input wire logic rteCheck,
  input wire logic [3:0] rteFormat,
  input wire logic [7:0] rteVersion,
  input wire logic modCheck,
  input wire logic [2:0] modOption,
  input wire logic [1:0] modType,
  input wire logic mmuIllegal,
  input wire logic coproc_state_restore_instr,
  input wire logic [15:0] cpFormatIn,
  input wire logic cpFormatError,
  output logic [15:0] cpFormatWord,
  output logic cpFormatStrobe,
  output logic [15:0] processorStatusWord,
  output logic excReq,
  output logic [7:0] excVector,
  output logic [31:0] excPc,
  output logic [15:0] excSrCopy,
  output logic excShortFrame,
  output logic intGo,
  output logic nextOk,
  output logic stopEnter
);
  import tfex_pkg::*;

  initial begin
    if (ADDR_W < 4 || ADDR_W > 32) begin
      $error("tfex_unit: ADDR_W out of range");
    end
  end

  function automatic logic traceHit(input logic [1:0] mode,
                                    input logic flow, input logic srw,
                                    input logic breakpoint_instr, input logic bkFlow);
    logic chg;
    chg = (breakpoint_instr ? bkFlow : flow) | srw;
    case (mode)
      `TFEX_TM_FLOW: traceHit = chg;
      `TFEX_TM_ALL: traceHit = 1'b1;
      default: traceHit = 1'b0;
    endcase
  endfunction

  tfex_state_t state_r, state_nxt;
  logic [15:0] psw_r;
  logic [7:0] version_r;
  logic [15:0] trcCnt_r;
  logic [1:0] modeLatch_r;
  logic busy_r;
  logic suspended_r;
  logic traceArm_r;
  logic forcedSeen_r;
  logic [31:0] tracePc_r;
  logic [31:0] fmtPc_r;
  logic cpWait_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic excReq_r;
  logic [7:0] excVector_r;
  logic [31:0] excPc_r;
  logic [15:0] excSrCopy_r;
  logic excShortFrame_r;
  logic intGo_r;
  logic stopEnter_r;
  logic [15:0] cpFormatWord_r;
  logic cpFormatStrobe_r;
  logic trcSent_r;
  logic nextOk_r;

  // APB decode; one wait state so that read data comes from a flop
  wire logic apbAcc = psel & penable;
  wire logic apbDone = apbAcc & pready_r;
  wire logic [ADDR_W-1:0] regAddr = paddr & ~ADDR_W'(3);
  wire logic hitPsw = regAddr == ADDR_W'(`TFEX_OFF_PSW);
  wire logic hitStat = regAddr == ADDR_W'(`TFEX_OFF_STATUS);
  wire logic hitVer = regAddr == ADDR_W'(`TFEX_OFF_VERSION);
  wire logic hitCnt = regAddr == ADDR_W'(`TFEX_OFF_TRCCNT);
  wire logic hitAny = hitPsw | hitStat | hitVer | hitCnt;
  wire logic wrPsw = apbDone & pwrite & hitPsw;
  wire logic wrVer = apbDone & pwrite & hitVer;
  wire logic [31:0] statusWord = {20'h00000, cpWait_r, suspended_r,
                                  busy_r, traceArm_r, 2'(state_r),
                                  modeLatch_r, psw_r[`TFEX_PSW_TCH],
                                  psw_r[`TFEX_PSW_TCL], 2'h0};
  wire logic [31:0] rdMux = hitPsw ? {16'h0000, psw_r} :
                            hitStat ? statusWord :
                            hitVer ? {24'h000000, version_r} :
                            hitCnt ? {16'h0000, trcCnt_r} : 32'h00000000;

  wire logic [1:0] curMode = {psw_r[`TFEX_PSW_TCH], psw_r[`TFEX_PSW_TCL]};
  wire logic startNow = instrStart & (state_r == ST_RUN);
  wire logic hitNow = traceHit(modeLatch_r, instrFlowChange, instrSrWrite,
                               instrIsBkpt, bkptReplaceFlow);
  // Illegal instructions never execute, so they never take a trace
  wire logic doneNow = busy_r & instrDone & ~instrIllegal;
  wire logic traceNow = doneNow & (traceArm_r | hitNow);
  wire logic stopTraced = instrIsStop & (modeLatch_r == `TFEX_TM_ALL);
  // One request per trace entry, whatever the core's acknowledge timing
  wire logic trcEntry = (state_r == ST_TRACE) & ~trcSent_r;
  wire logic busy_nxt = startNow | (busy_r & (instrSuspend | ~instrDone));

  // Format checks
  wire logic [15:0] fmtMaskSh = `TFEX_FMT_VALID_MASK >> rteFormat;
  wire logic rteFmtOk = fmtMaskSh[0];
  wire logic rteBad = rteCheck & (~rteFmtOk |
    ((rteFormat == `TFEX_FMT_LONG_BUS) & (rteVersion != version_r)));
  wire logic modBad = modCheck & ((modOption != `TFEX_MOD_OPT_OK) |
    (modType != `TFEX_MOD_TYPE_OK) | mmuIllegal);
  wire logic cpBad = cpWait_r & cpFormatError;
  wire logic fmtFail = rteBad | modBad | cpBad;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (doneNow & forcedExc) begin
          state_nxt = ST_FORCED;
        end else if (traceNow) begin
          state_nxt = ST_TRACE;
        end else if (doneNow & intPending) begin
          state_nxt = ST_INT;
        end
      end
      ST_FORCED: begin
        if (excDone) begin
          state_nxt = forcedSeen_r ? ST_TRACE :
                      (intPending ? ST_INT : ST_RUN);
        end
      end
      ST_TRACE: begin
        if (trcSent_r && excReq_r == 1'b0 && excDone) begin
          state_nxt = intPending ? ST_INT : ST_RUN;
        end
      end
      ST_INT: state_nxt = ST_RUN;
      default: state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= ST_RUN;
      trcSent_r <= 1'b0;
      nextOk_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      trcSent_r <= (state_nxt == ST_TRACE) & (trcSent_r | trcEntry);
      nextOk_r <= (state_nxt == ST_RUN) & ~busy_nxt;
    end
  end

  // Instruction tracking: mode sampled at start, held over suspension
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      modeLatch_r <= `TFEX_TM_NONE;
      busy_r <= 1'b0;
      suspended_r <= 1'b0;
      traceArm_r <= 1'b0;
      forcedSeen_r <= 1'b0;
      tracePc_r <= 32'h00000000;
    end else begin
      if (startNow) begin
        modeLatch_r <= curMode;
        busy_r <= 1'b1;
        traceArm_r <= 1'b0;
        suspended_r <= 1'b0;
      end else if (busy_r & instrSuspend) begin
        // Flow flags may not repeat on resume, so keep the decision
        suspended_r <= 1'b1;
        traceArm_r <= traceArm_r | hitNow;
      end else if (busy_r & instrDone) begin
        busy_r <= 1'b0;
        suspended_r <= 1'b0;
        traceArm_r <= 1'b0;
      end
      if (state_r == ST_RUN && doneNow) begin
        forcedSeen_r <= forcedExc & traceNow;
        tracePc_r <= nextPc;
      end
    end
  end

  // Status word: trace entry wins over software and core loads
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      psw_r <= `TFEX_PSW_RST;
      version_r <= `TFEX_VERSION_RST;
      trcCnt_r <= 16'h0000;
    end else begin
      if (trcEntry) begin
        psw_r[`TFEX_PSW_SUP] <= 1'b1;
        psw_r[`TFEX_PSW_TCH] <= 1'b0;
        psw_r[`TFEX_PSW_TCL] <= 1'b0;
        trcCnt_r <= trcCnt_r + 16'h0001;
      end else if (srLoad) begin
        psw_r <= srLoadData;
      end else if (wrPsw) begin
        psw_r <= pwdata[15:0];
      end
      if (wrVer) begin
        version_r <= pwdata[7:0];
      end
    end
  end

  // Exception request port
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      excReq_r <= 1'b0;
      excVector_r <= 8'h00;
      excPc_r <= 32'h00000000;
      excSrCopy_r <= 16'h0000;
      excShortFrame_r <= 1'b0;
      intGo_r <= 1'b0;
      stopEnter_r <= 1'b0;
      fmtPc_r <= 32'h00000000;
    end else begin
      excReq_r <= 1'b0;
      intGo_r <= state_r == ST_INT;
      stopEnter_r <= doneNow & instrIsStop & ~stopTraced;
      if (trcEntry) begin
        excReq_r <= 1'b1;
        excVector_r <= `TFEX_VEC_TRACE;
        excPc_r <= tracePc_r;
        excSrCopy_r <= psw_r;
        excShortFrame_r <= 1'b0;
      end else if (fmtFail) begin
        excReq_r <= 1'b1;
        excVector_r <= `TFEX_VEC_FORMAT;
        excPc_r <= cpBad ? fmtPc_r : curPc;
        excSrCopy_r <= psw_r;
        excShortFrame_r <= 1'b1;
      end
      if (coproc_state_restore_instr) begin
        fmtPc_r <= curPc;
      end
    end
  end

  // Coprocessor restore hand-over
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cpFormatWord_r <= 16'h0000;
      cpFormatStrobe_r <= 1'b0;
      cpWait_r <= 1'b0;
    end else begin
      cpFormatStrobe_r <= coproc_state_restore_instr;
      if (coproc_state_restore_instr) begin
        cpFormatWord_r <= cpFormatIn;
        cpWait_r <= 1'b1;
      end else if (cpWait_r & (cpFormatError | instrDone)) begin
        cpWait_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= apbAcc & ~pready_r;
      pslverr_r <= apbAcc & ~pready_r & ~hitAny;
      prdata_r <= (apbAcc & ~pready_r & ~pwrite) ? rdMux : 32'h00000000;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign processorStatusWord = psw_r;
  assign excReq = excReq_r;
  assign excVector = excVector_r;
  assign excPc = excPc_r;
  assign excSrCopy = excSrCopy_r;
  assign excShortFrame = excShortFrame_r;
  assign intGo = intGo_r;
  assign nextOk = nextOk_r;
  assign stopEnter = stopEnter_r;
  assign cpFormatWord = cpFormatWord_r;
  assign cpFormatStrobe = cpFormatStrobe_r;

  sequence s_traceEntry;
    trcEntry ##1 (excReq & excVector == `TFEX_VEC_TRACE);
  endsequence

  a_mode_none_quiet: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (state_r == ST_RUN && doneNow && !traceArm_r && !forcedExc &&
     modeLatch_r == `TFEX_TM_NONE) |=> state_r != ST_TRACE)
    else $error("trace taken with tracing off");
  a_mode_all_trace: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (state_r == ST_RUN && doneNow && !forcedExc &&
     modeLatch_r == `TFEX_TM_ALL) |=> state_r == ST_TRACE)
    else $error("all-mode instruction not traced");
  a_flow_seq_skip: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (state_r == ST_RUN && doneNow && !traceArm_r && !forcedExc &&
     modeLatch_r == `TFEX_TM_FLOW && !instrFlowChange && !instrSrWrite &&
     !instrIsBkpt) |=> state_r != ST_TRACE)
    else $error("sequential instruction traced");
  a_mode_rsvd: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (state_r == ST_RUN && doneNow && !traceArm_r && !forcedExc &&
     modeLatch_r == 2'h3) |=> state_r != ST_TRACE)
    else $error("reserved mode traced");
  a_trace_entry_psw: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    s_traceEntry |-> (processorStatusWord[`TFEX_PSW_SUP] &&
     !processorStatusWord[`TFEX_PSW_TCH] &&
     !processorStatusWord[`TFEX_PSW_TCL] && !excShortFrame))
    else $error("trace entry status word wrong");
  a_trace_pc: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (state_r == ST_RUN && traceNow && !forcedExc) |=>
    ##1 (excReq && excVector == `TFEX_VEC_TRACE &&
         excPc == $past(nextPc, 2)))
    else $error("trace vector or pc wrong");
  a_forced_first: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (state_r == ST_RUN && doneNow && forcedExc) |=>
    (state_r == ST_FORCED && !excReq))
    else $error("forced exception not first");
  a_int_after_trace: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (state_r == ST_TRACE) |-> !intGo)
    else $error("interrupt granted during trace");
  a_fmt_short_frame: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (rteBad && !trcEntry) |=> (excReq && excShortFrame &&
     excVector == `TFEX_VEC_FORMAT && excPc == $past(curPc)))
    else $error("format error frame wrong");
  a_stop_no_halt: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (doneNow && instrIsStop && stopTraced) |=> !stopEnter)
    else $error("stopped under all-tracing");
endmodule // tfex_unit

// >>> tb/tfex_cop_model.sv
`timescale 1ns/1ps
module tfex_cop_model #(
  parameter logic [7:0] GOOD_ID = 8'h5A
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cpFormatStrobe,
  input wire logic [15:0] cpFormatWord,
  input wire logic slow,
  input wire logic denyRights,
  output logic cpFormatError,
  output logic mmuIllegal
);
  logic [3:0] cnt = 4'h0;
  logic pend = 1'h0;
  // Memory manager veto is a plain level seen with the call check
  assign mmuIllegal = denyRights;
  always @(posedge clk_sys) begin
    cpFormatError <= 1'h0;
    if (sys_rst) begin
      pend <= 1'h0;
      cnt <= 4'h0;
    end else if (cpFormatStrobe) begin
      // Only the null frame and our own frame id are known
      pend <= cpFormatWord[15:8] != GOOD_ID &&
        cpFormatWord[15:8] != 8'h00;
      cnt <= slow ? 4'h5 : 4'h0;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (pend) begin
      cpFormatError <= 1'h1;
      pend <= 1'h0;
    end
  end
endmodule // tfex_cop_model

// >>> tb/tfex_unit_tb_top.sv
`timescale 1ns/1ps
`include "tfex_defines.svh"
module tfex_unit_tb_top;
  logic clk_sys = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, instrStart = 1'h0, instrDone = 1'h0;
  logic instrSuspend = 1'h0, instrIllegal = 1'h0, instrFlowChange = 1'h0;
  logic instrSrWrite = 1'h0, instrIsBkpt = 1'h0, bkptReplaceFlow = 1'h0;
  logic instrIsStop = 1'h0, forcedExc = 1'h0, excDone = 1'h0;
  logic intPending = 1'h0, srLoad = 1'h0, rteCheck = 1'h0, modCheck = 1'h0;
  logic coproc_state_restore_instr = 1'h0, slow = 1'h0, deny = 1'h0, forcedFin = 1'h0;
  logic stopOk = 1'h0;
  logic traceSeen = 1'h0, pready, pslverr, cpFormatStrobe, excReq;
  logic excShortFrame, intGo, nextOk, stopEnter, cpFormatError, mmuIllegal;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, curPc = 32'h0, nextPc = 32'h0, prdata, excPc;
  logic [31:0] lfsrState = 32'h000133BE;
  logic [15:0] srLoadData = 16'h0, cpFormatIn = 16'h0, cpFormatWord;
  logic [15:0] processorStatusWord, excSrCopy;
  logic [7:0] rteVersion = 8'h0, excVector;
  logic [3:0] rteFormat = 4'h0;
  logic [2:0] modOption = 3'h0;
  logic [1:0] modType = 2'h0;
  logic [56:0] expQ[$], e;
  logic [32:0] r;
  int badCount = 0, nCompared = 0, cyc = 0, intGoCnt = 0, nStop = 0;
  localparam logic [7:0] KIND [6] = '{8'h00, 8'h02, 8'h04, 8'h18, 8'h08,
    8'h01};
  localparam logic [18:0] FMT [12] = '{{2'h0, 16'h0301, 1'h1},
    {2'h0, 16'h0B02, 1'h1}, {2'h0, 16'h0B01, 1'h0}, {2'h0, 16'h0001, 1'h0},
    {2'h1, 16'h0004, 1'h1}, {2'h1, 16'h0001, 1'h1}, {2'h1, 16'h0020, 1'h1},
    {2'h1, 16'h0000, 1'h0}, {2'h2, 16'h0000, 1'h0}, {2'h2, 16'h5A00, 1'h0},
    {2'h2, 16'h3300, 1'h1}, {2'h2, 16'h3300, 1'h1}};

  tfex_unit dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instrStart(instrStart), .instrDone(instrDone),
    .instrSuspend(instrSuspend), .instrIllegal(instrIllegal),
    .instrFlowChange(instrFlowChange), .instrSrWrite(instrSrWrite),
    .instrIsBkpt(instrIsBkpt), .bkptReplaceFlow(bkptReplaceFlow),
    .instrIsStop(instrIsStop), .forcedExc(forcedExc), .excDone(excDone),
    .intPending(intPending), .curPc(curPc), .nextPc(nextPc),
    .srLoad(srLoad), .srLoadData(srLoadData), .rteCheck(rteCheck),
    .rteFormat(rteFormat), .rteVersion(rteVersion), .modCheck(modCheck),
    .modOption(modOption), .modType(modType), .mmuIllegal(mmuIllegal),
    .coproc_state_restore_instr(coproc_state_restore_instr), .cpFormatIn(cpFormatIn),
    .cpFormatError(cpFormatError), .cpFormatWord(cpFormatWord),
    .cpFormatStrobe(cpFormatStrobe),
    .processorStatusWord(processorStatusWord), .excReq(excReq),
    .excVector(excVector), .excPc(excPc), .excSrCopy(excSrCopy),
    .excShortFrame(excShortFrame), .intGo(intGo), .nextOk(nextOk),
    .stopEnter(stopEnter));
  tfex_cop_model cop_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .cpFormatStrobe(cpFormatStrobe), .cpFormatWord(cpFormatWord),
    .slow(slow), .denyRights(deny), .cpFormatError(cpFormatError),
    .mmuIllegal(mmuIllegal));

  always #12.5 clk_sys = ~clk_sys;
  // Core side acknowledges each requested exception one cycle after it is raised, forced ones on forcedFin
  always @(posedge clk_sys) excDone <= excReq | forcedFin;

  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic stopTest;
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmpExc(input logic [56:0] got, input logic [56:0] exp);
    nCompared++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected event at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmpApb(input logic [32:0] got, input logic [32:0] exp);
    nCompared++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected read at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [32:0] rd);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    // Only the bench timeout ends a wait for the slave
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'h1);
    rd = {pslverr, prdata};
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_sys);
  endtask

  task automatic runInstr(input logic [1:0] m, input logic [7:0] f,
      input logic tr);
    logic [15:0] psw;
    psw = 16'h2700 | {m ^ 2'h3, 14'h0};
    apb(1'h1, `TFEX_OFF_PSW, {16'h0, 16'h2700 | {m, 14'h0}}, r);
    while (nextOk !== 1'h1) @(posedge clk_sys);
    instrStart <= 1'h1;
    srLoad <= f[5];
    srLoadData <= psw;
    @(posedge clk_sys);
    instrStart <= 1'h0;
    srLoad <= 1'h0;
    // Bits changed mid-instruction must not alter this decision
    apb(1'h1, `TFEX_OFF_PSW, {16'h0, psw}, r);
    {instrIsStop, bkptReplaceFlow, instrIsBkpt} <= f[5:3];
    {instrSrWrite, instrFlowChange, instrIllegal} <= f[2:0];
    lfsrState = nextRand(lfsrState);
    nextPc <= {lfsrState[31:1], 1'h0};
    instrSuspend <= f[6];
    @(posedge clk_sys);
    instrSuspend <= 1'h0;
    if (f[6]) repeat (3) @(posedge clk_sys);
    forcedExc <= f[7];
    instrDone <= 1'h1;
    if (tr && !f[7]) expQ.push_back({8'h09, nextPc, psw, 1'h0});
    @(posedge clk_sys);
    instrDone <= 1'h0;
    forcedExc <= 1'h0;
    if (f[7]) begin
      repeat (4) @(posedge clk_sys);
      if (tr) expQ.push_back({8'h09, nextPc, psw, 1'h0});
      forcedFin <= 1'h1;
      @(posedge clk_sys);
      forcedFin <= 1'h0;
    end
    repeat (8) @(posedge clk_sys);
    cmpExc(57'(expQ.size()), 57'h0);
  endtask

  task automatic fmtOp(input logic [18:0] t);
    lfsrState = nextRand(lfsrState);
    curPc <= {lfsrState[31:1], 1'h0};
    slow <= lfsrState[3];
    @(posedge clk_sys);
    {rteFormat, rteVersion} <= t[12:1];
    {modOption, modType} <= t[5:1];
    deny <= t[6];
    cpFormatIn <= t[16:1];
    rteCheck <= t[18:17] == 2'h0;
    modCheck <= t[18:17] == 2'h1;
    coproc_state_restore_instr <= t[18:17] == 2'h2;
    if (t[0]) expQ.push_back({8'h0E, curPc, 16'h0, 1'h1});
    @(posedge clk_sys);
    {rteCheck, modCheck, coproc_state_restore_instr} <= 3'h0;
    repeat (12) @(posedge clk_sys);
    cmpExc(57'(expQ.size()), 57'h0);
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 6000) begin
      badCount++;
      stopTest;
    end
  end

  always @(posedge clk_sys) begin
    if (excReq === 1'h1) begin
      traceSeen = 1'h1;
      e = expQ.size() ? expQ.pop_front() : 57'h0;
      cmpExc({excVector, excPc, excVector == 8'h09 ? excSrCopy : 16'h0,
        excShortFrame}, e);
      if (excVector == 8'h09)
        cmpExc(57'(processorStatusWord[15:13]), 57'h1);
    end
    if (intGo === 1'h1) begin
      intGoCnt++;
      cmpExc(traceSeen, 1'h1);
    end
    if (stopEnter === 1'h1) begin
      nStop++;
      cmpExc(57'(stopOk), 57'h1);
    end
    if (cpFormatStrobe === 1'h1) cmpExc(cpFormatWord, cpFormatIn);
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'h0;
    @(posedge clk_sys);
    apb(1'h0, `TFEX_OFF_PSW, 32'h0, r);
    cmpApb(r, {17'h0, `TFEX_PSW_RST});
    apb(1'h0, `TFEX_OFF_VERSION, 32'h0, r);
    cmpApb(r, 33'h000000001);
    apb(1'h0, 12'h010, 32'h0, r);
    cmpApb(r, 33'h100000000);
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 6; k++) begin
        runInstr(m[1:0], KIND[k], k != 5 && (m == 2 || (m == 1 && k inside
          {1, 2, 3})));
      end
    end
    traceSeen = 1'h0;
    intPending <= 1'h1;
    runInstr(2'h2, 8'h00, 1'h1);
    intPending <= 1'h0;
    cmpExc(intGoCnt > 0, 1'h1);
    runInstr(2'h2, 8'h40, 1'h1);
    runInstr(2'h2, 8'h80, 1'h1);
    runInstr(2'h2, 8'h20, 1'h1);
    // An untraced stop must still reach the stopped state
    stopOk = 1'h1;
    runInstr(2'h0, 8'h20, 1'h0);
    stopOk = 1'h0;
    cmpExc(57'(nStop), 57'h1);
    for (int i = 0; i < 12; i++) fmtOp(FMT[i]);
    stopTest;
  end
endmodule // tfex_unit_tb_top
